// *** shared/spwm_pkg.sv ***
package spwm_pkg;

	// ************************************************
	// Timing
	// ************************************************
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned CARRIER_MHZ = 19_530_000; // 19.53 kHz in millihertz
	localparam int unsigned PERIOD_CYC  = 32'((CLK_HZ * 64'd1000) / CARRIER_MHZ);
	localparam int unsigned CNT_W       = 10;
	localparam logic [CNT_W-1:0] CNT_MAX   = CNT_W'(PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;

	// ************************************************
	// Command and duty
	// ************************************************
	localparam int unsigned CMD_W = 16;
	localparam logic [CMD_W-1:0] CMD_FULL = 16'h8000;
	localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
	localparam int unsigned DUTY_W = CNT_W + 1;
	localparam logic [DUTY_W-1:0] DUTY_RESET = 11'h000;

	typedef enum logic [0:0]
	{
		SPWM_BIPOLAR  = 1'b0,
		SPWM_UNIPOLAR = 1'b1
	} spwm_mode_t;

	typedef struct packed
	{
		logic              valid;
		logic [CMD_W-1:0]  effort;
	} spwm_cmd_t;

	typedef struct packed
	{
		logic pwm;
		logic dir;
	} spwm_out_t;

endpackage : spwm_pkg

// *** src/spwm_servo_pwm.sv ***
`timescale 1ns/1ns
module spwm_servo_pwm
(
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               srst,
	// Configuration
	input  wire spwm_pkg::spwm_mode_t output_mode,
	input  wire logic               axis_enable,
	// Servo command
	input  wire spwm_pkg::spwm_cmd_t  cmd,
	// Driver pins
	output logic                    pwm_out,
	output logic                    pwm_oe,
	output logic                    dir_out,
	output logic                    period_start
);
	import spwm_pkg::*;

	// ************************************************
	// Carrier counter
	// ************************************************
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	always_comb
	begin
		if (cnt == CNT_MAX)
			next_cnt = CNT_RESET;
		else
			next_cnt = cnt + 10'h001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cnt <= CNT_RESET;
		else
			cnt <= next_cnt;
	end

	// ************************************************
	// Pending command
	// ************************************************
	logic [CMD_W-1:0] pend_eff;
	logic [CMD_W-1:0] next_pend_eff;

	always_comb
	begin
		// Last command before a boundary wins
		if (cmd.valid)
			next_pend_eff = cmd.effort;
		else
			next_pend_eff = pend_eff;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pend_eff <= CMD_RESET;
		else
			pend_eff <= next_pend_eff;
	end

	// ************************************************
	// Mode decode
	// ************************************************
	logic uni_sel;

	always_comb
	begin
		case (output_mode)
			SPWM_UNIPOLAR:
				uni_sel = 1'b1;
			SPWM_BIPOLAR:
				uni_sel = 1'b0;
			default:
				uni_sel = 1'b0;
		endcase
	end

	// ************************************************
	// Magnitude and sign
	// ************************************************
	logic                    sign_bit;
	logic [CMD_W-1:0]        uni_mag;
	logic [CMD_W-1:0]        bi_mag;

	always_comb
	begin
		sign_bit = next_pend_eff[CMD_W-1];
		// Full negative scale stays exact
		if (sign_bit)
			uni_mag = ~next_pend_eff + 16'h0001;
		else
			uni_mag = next_pend_eff;
		// Offset binary around half scale
		bi_mag = next_pend_eff ^ CMD_FULL;
	end

	// ************************************************
	// Duty computation
	// ************************************************
	logic [CNT_W+CMD_W-1:0]  uni_prod;
	logic [CNT_W+CMD_W-1:0]  bi_prod;
	logic [DUTY_W-1:0]       raw_duty;

	always_comb
	begin
		uni_prod = 26'(uni_mag) * 26'(PERIOD_CYC);
		bi_prod  = 26'(bi_mag) * 26'(PERIOD_CYC);
		if (uni_sel)
			raw_duty = DUTY_W'(uni_prod >> (CMD_W - 1));
		else
			raw_duty = DUTY_W'(bi_prod >> CMD_W);
	end

	// ************************************************
	// Axis enable gate
	// ************************************************
	logic [DUTY_W-1:0]       gated_duty;
	logic                    gated_dir;

	always_comb
	begin
		if (axis_enable)
		begin
			gated_duty = raw_duty;
			gated_dir  = uni_sel & sign_bit;
		end
		else
		begin
			// Disabled axis stays off
			gated_duty = DUTY_RESET;
			gated_dir  = 1'b0;
		end
	end

	// ************************************************
	// Period boundary
	// ************************************************
	logic boundary;
	logic start;
	logic next_start;

	always_comb
	begin
		boundary   = (next_cnt == CNT_RESET);
		next_start = boundary;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			start <= 1'b0;
		else
			start <= next_start;
	end

	// ************************************************
	// Duty held for one period
	// ************************************************
	logic [DUTY_W-1:0] duty;
	logic [DUTY_W-1:0] next_duty;

	always_comb
	begin
		next_duty = duty;
		if (boundary)
			next_duty = gated_duty;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			duty <= DUTY_RESET;
		else
			duty <= next_duty;
	end

	// ************************************************
	// Direction held for one period
	// ************************************************
	logic dir;
	logic next_dir;

	always_comb
	begin
		next_dir = dir;
		if (boundary)
			next_dir = gated_dir;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			dir <= 1'b0;
		else
			dir <= next_dir;
	end

	// ************************************************
	// PWM level
	// ************************************************
	logic pwm;
	logic next_pwm;

	always_comb
	begin
		// On while counter is below duty
		next_pwm = ({1'b0, next_cnt} < next_duty);
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pwm <= 1'b0;
		else
			pwm <= next_pwm;
	end

	// ************************************************
	// Open collector: pull low when pwm is low
	// ************************************************
	assign pwm_out      = pwm;
	assign pwm_oe       = ~pwm;
	assign dir_out      = dir;
	assign period_start = start;

endmodule : spwm_servo_pwm

// *** bench/spwm_properties.sv ***
`timescale 1ns/1ns
module spwm_properties
	import spwm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire spwm_mode_t output_mode,
	input wire logic dir_out,
	input wire logic pwm_out,
	input wire logic pwm_oe,
	input wire logic period_start
);
	logic [9:0] c;
	logic s;
	always_ff @(posedge sys_clk)
	begin
		c <= (srst || period_start) ? 10'h000 : c + 10'h001;
		s <= !srst && (s || period_start);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	period_len_a: assert property (period_start && s |-> c == 10'h1FF) else $error("period");
	start_pulse_a: assert property (period_start |=> !period_start) else $error("pulse");
	bipolar_dir_a: assert property (period_start && $past(output_mode) == SPWM_BIPOLAR |-> !dir_out) else $error("dir");
	start_gap_a: assert property (period_start |=> (!period_start) [*8]) else $error("start gap");
	dir_hold_a: assert property (!period_start |-> $stable(dir_out)) else $error("dir hold");
	pwm_rise_a: assert property ($rose(pwm_out) |-> period_start) else $error("pwm rise");
	pin_polarity_a: assert property (pwm_oe != pwm_out) else $error("pin polarity");
	cover property (period_start && dir_out);
	cover property (period_start && s);
	cover property (period_start && output_mode == SPWM_UNIPOLAR);
endmodule : spwm_properties
bind spwm_servo_pwm spwm_properties chk (.sys_clk(sys_clk), .srst(srst), .output_mode(output_mode),
	.dir_out(dir_out), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .period_start(period_start));

// *** bench/spwm_bridge_model.sv ***
`timescale 1ns/1ns
module spwm_bridge_model
(
	input wire logic sys_clk,
	input wire logic pin,
	input wire logic start,
	output logic [10:0] duty
);
	logic [10:0] acc;
	// On-time of the last carrier period
	always_ff @(posedge sys_clk)
		if (start)
		begin
			duty <= acc;
			acc <= {10'h000, pin};
		end
		else
			acc <= acc + {10'h000, pin};
endmodule : spwm_bridge_model

// *** bench/spwm_servo_pwm_bench.sv ***
`timescale 1ns/1ns
module spwm_servo_pwm_bench;
	import spwm_pkg::*;
	logic sys_clk = 0, srst = 1, axis_enable = 1, pwm_out, pwm_oe, dir_out, period_start;
	spwm_mode_t output_mode = SPWM_BIPOLAR;
	spwm_cmd_t cmd = '0;
	logic [10:0] duty;
	int err_count = 0, total_checks = 0, cyc = 0;
	// Open collector with pull-up
	wire logic pin = pwm_oe ? 1'b0 : 1'b1;
	spwm_servo_pwm uut (.sys_clk(sys_clk), .srst(srst), .output_mode(output_mode), .axis_enable(axis_enable),
		.cmd(cmd), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .dir_out(dir_out), .period_start(period_start));
	spwm_bridge_model hb (.sys_clk(sys_clk), .pin(pin), .start(period_start), .duty(duty));
	initial forever #50 sys_clk = !sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			err_count++;
			give_verdict();
		end
	end
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected dir_duty exp %h seen %h", exp, seen);
		end
	endtask : chk
	task run(input spwm_mode_t m, input logic en, input logic [15:0] e, input logic [11:0] exp);
		output_mode = m;
		axis_enable = en;
		cmd = '{1'b1, e};
		@(negedge sys_clk);
		cmd.valid = 1'b0;
		repeat (2)
			do @(negedge sys_clk); while (period_start !== 1'b1);
		@(negedge sys_clk);
		chk({dir_out, duty}, exp);
	endtask : run
	task give_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (4) @(negedge sys_clk);
		srst = 0;
		run(SPWM_BIPOLAR, 1'b1, 16'h0000, 12'h100);
		run(SPWM_UNIPOLAR, 1'b1, 16'h0000, 12'h000);
		run(SPWM_UNIPOLAR, 1'b1, 16'hC000, 12'h900);
		run(SPWM_UNIPOLAR, 1'b1, 16'h8000, 12'hA00);
		run(SPWM_BIPOLAR, 1'b1, 16'h4000, 12'h180);
		run(SPWM_BIPOLAR, 1'b1, 16'h8000, 12'h000);
		run(SPWM_BIPOLAR, 1'b0, 16'h4000, 12'h000);
		give_verdict();
	end
endmodule : spwm_servo_pwm_bench
